// file: hdl/core_defs.svh
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
// Timing
`define CLK_PER_CYCLE   3'h4
`define PHASE_LAST      2'h3
// Reset values
`define RST_PC          13'h0000
`define RST_BYTE        8'h00
`define RST_SP          4'h0
// Special data memory address of the program counter low byte
`define ADDR_PCL        8'h02
// Instruction field positions (16-bit word)
`define OP_HI           15
`define OP_LO           10
`define BIT_HI          9
`define BIT_LO          7
`define ADR_HI          7
`define ADR_LO          0
`define JADR_HI         12
`define JADR_LO         0
// Opcodes (6-bit major)
`define OP_NOP          6'h00
`define OP_SZ           6'h01
`define OP_SZA          6'h02
`define OP_SZB          6'h03
`define OP_SNZB         6'h04
`define OP_SIZ          6'h05
`define OP_SDZ          6'h06
`define OP_INCREMENT_TO_ACC_SKIP_IF_ZERO         6'h07
`define OP_DECREMENT_TO_ACC_SKIP_IF_ZERO         6'h08
`define OP_CALL         6'h09
`define OP_JMP          6'h0A
`define OP_RET          6'h0B
`define OP_RETA         6'h0C
`define OP_INTERRUPT_RETURN         6'h0D
`define OP_TRDC         6'h0E
`define OP_TRDL         6'h0F
`define OP_CLR          6'h10
`define OP_CLRB         6'h11
`define OP_SWAP         6'h12
`define OP_NIBBLE_EXCHANGE_TO_ACC        6'h13
`define OP_WCLR         6'h14
`define OP_WPRE1        6'h15
`define OP_WPRE2        6'h16
`define OP_HALT         6'h17
`define OP_ADD          6'h18
`define OP_ADD_TO_MEMORY         6'h19
`define OP_ADDI         6'h1A
`define OP_ADC          6'h1B
`define OP_ADD_WITH_CARRY_TO_MEMORY         6'h1C
`define OP_AND          6'h1D
`define OP_BITWISE_AND_TO_MEMORY         6'h1E
`define OP_ANDI         6'h1F
`define LAST_PAGE       5'h1F
`endif

// file: hdl/core_pkg.sv
package core_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_HALTED} state_e;
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
    logic to;
    logic power_down_flag;
  } flags_s;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmem_req_s;
endpackage

// file: hdl/alu_add.sv
`timescale 1ns/100ps
module alu_add
  import core_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            ov,
  output logic            ac,
  output logic            co
);
  logic [4:0] lo;
  logic [8:0] full;
  // Nibble and full sums give carry out of bit 3 and bit 7
  always_comb begin
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    sum  = full[7:0];
    co   = full[8];
    ac   = lo[4];
    ov   = (a[7] == b[7]) && (sum[7] != a[7]);
  end
endmodule // alu_add

// file: hdl/ret_stack.sv
`timescale 1ns/100ps
`include "core_defs.svh"
module ret_stack
  import core_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 13
)(
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          push,
  input  wire logic [AW-1:0] wdata,
  input  wire logic [3:0]    waddr,
  input  wire logic [3:0]    raddr,
  output logic      [AW-1:0] rdata
);
  logic [AW-1:0] mem [DEPTH];
  // Registered read keeps the top off any combinational path
  always_ff @(posedge clk) begin
    if (ce) begin
      if (push) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // ret_stack

// file: hdl/insn_core.sv
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "core_defs.svh"
module insn_core
  import core_pkg::*;
#(
  parameter int WDT_W = 8
)(
  input  wire logic         MCLK,
  input  wire logic         RESET_N,
  input  wire logic         CE,
  input  wire logic [15:0]  PROG_DATA,
  input  wire logic [7:0]   DMEM_RDATA,
  input  wire logic         WAKE,
  input  wire logic         WDT_TICK,
  output logic      [12:0]  PROG_ADDR,
  output logic              DMEM_WE,
  output logic      [7:0]   DMEM_ADDR,
  output logic      [7:0]   DMEM_WDATA,
  output logic      [7:0]   ACC,
  output logic      [7:0]   TABLE_HIGH_LATCH,
  output logic      [5:0]   FLAGS,
  output logic              GLOBAL_INTERRUPT_ENABLE,
  output logic              HALTED,
  output logic [WDT_W-1:0]  WATCHDOG_COUNTER
);

  // All module state in one packed struct
  typedef struct packed {
    state_e           st;
    logic [1:0]       phase;
    logic [12:0]      pc;
    logic [15:0]      ir;
    logic [3:0]       sp;
    logic [7:0]       acc;
    logic [7:0]       tbh;
    flags_s           fl;
    logic             gie;
    logic             pre1;
    logic             pre2;
    logic [WDT_W-1:0] wdt;
    dmem_req_s        dm;
    logic             table_pend;
    logic [12:0]      fetch_addr;
  } core_s;

  core_s s_q, s_d;
  logic [12:0] stk_top;
  logic        stk_push;
  logic [12:0] ret_addr;
  logic [7:0]  add_sum;
  logic        add_ov;
  logic        add_ac;
  logic        add_co;
  logic [7:0]  add_b;
  logic        add_cin;

  // Opcode field decode, shared by the datapath and the assertions
  function automatic logic [5:0] opc(input logic [15:0] w);
    return w[`OP_HI:`OP_LO];
  endfunction

  function automatic logic writes_pcl(input logic [15:0] w);
    return w[`ADR_HI:`ADR_LO] == `ADDR_PCL;
  endfunction

  // Adder operand select: immediate form uses the instruction byte
  always_comb begin
    add_b   = (opc(s_q.ir) == `OP_ADDI) ? s_q.ir[`ADR_HI:`ADR_LO] : DMEM_RDATA;
    add_cin = (opc(s_q.ir) == `OP_ADC || opc(s_q.ir) == `OP_ADD_WITH_CARRY_TO_MEMORY) ? s_q.fl.c : 1'b0;
  end

  alu_add u_add (
    .a   (s_q.acc),
    .b   (add_b),
    .cin (add_cin),
    .sum (add_sum),
    .ov  (add_ov),
    .ac  (add_ac),
    .co  (add_co)
  );

  ret_stack #(.DEPTH(16), .AW(13)) u_stk (
    .clk   (MCLK),
    .ce    (CE),
    .push  (stk_push),
    .wdata (ret_addr),
    .waddr (s_q.sp),
    .raddr (s_q.sp - 4'h1),
    .rdata (stk_top)
  );

  // Push the return address while the call executes, at the old stack pointer; the registered
  // top has settled long before any return can read it
  assign ret_addr = s_q.pc + 13'h0001;
  assign stk_push = (s_q.st == ST_RUN) && (s_q.phase == `PHASE_LAST) && (opc(s_q.ir) == `OP_CALL);

  // Next-state: fetch in phase 0, data memory address in phase 1, execute in last phase
  always_comb begin
    logic [7:0] m;
    logic [7:0] res;
    logic       skip;
    logic       wr;
    logic       extra;
    logic [2:0] bsel;
    m     = DMEM_RDATA;
    res   = `RST_BYTE;
    skip  = 1'b0;
    wr    = 1'b0;
    extra = 1'b0;
    bsel  = s_q.ir[`BIT_HI:`BIT_LO];
    s_d   = s_q;
    s_d.dm.we = 1'b0;
    if (WDT_TICK && s_q.st != ST_HALTED) begin
      s_d.wdt = s_q.wdt + {{(WDT_W-1){1'b0}}, 1'b1};
    end
    s_d.phase = s_q.phase + 2'h1;
    if (s_q.phase == 2'h0 && s_q.st == ST_RUN) begin
      s_d.ir = PROG_DATA;
    end
    if (s_q.phase == 2'h1 && s_q.st == ST_RUN) begin
      s_d.dm.addr = s_q.ir[`ADR_HI:`ADR_LO];
    end
    case (s_q.st)
      ST_HALTED: begin
        s_d.phase = 2'h0;
        if (WAKE) begin
          s_d.st = ST_RUN;
        end
      end
      ST_EXTRA: begin
        // Extra instruction cycle: table fetch data arrives here
        if (s_q.phase == `PHASE_LAST) begin
          if (s_q.table_pend) begin
            s_d.dm.we    = 1'b1;
            s_d.dm.wdata = PROG_DATA[7:0];
            s_d.tbh      = PROG_DATA[15:8];
            s_d.table_pend = 1'b0;
            s_d.st = writes_pcl(s_q.ir) ? ST_EXTRA : ST_RUN;
            if (writes_pcl(s_q.ir)) begin
              s_d.pc = {s_q.pc[12:8], PROG_DATA[7:0]};
            end
          end else begin
            s_d.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (s_q.phase == `PHASE_LAST) begin
          s_d.pc = s_q.pc + 13'h0001;
          case (opc(s_q.ir))
            `OP_SZ:   skip = (m == 8'h00);
            `OP_SZA: begin
              s_d.acc = m;
              skip    = (m == 8'h00);
            end
            `OP_SZB:  skip = ~m[bsel];
            `OP_SNZB: skip = m[bsel];
            `OP_SIZ, `OP_SDZ: begin
              res  = (opc(s_q.ir) == `OP_SIZ) ? m + 8'h01 : m - 8'h01;
              wr   = 1'b1;
              skip = (res == 8'h00);
            end
            `OP_INCREMENT_TO_ACC_SKIP_IF_ZERO, `OP_DECREMENT_TO_ACC_SKIP_IF_ZERO: begin
              res     = (opc(s_q.ir) == `OP_INCREMENT_TO_ACC_SKIP_IF_ZERO) ? m + 8'h01 : m - 8'h01;
              s_d.acc = res;
              skip    = (res == 8'h00);
            end
            `OP_CALL, `OP_JMP: begin
              s_d.pc = s_q.ir[`JADR_HI:`JADR_LO];
              if (opc(s_q.ir) == `OP_CALL) begin
                s_d.sp = s_q.sp + 4'h1;
              end
              extra = 1'b1;
            end
            `OP_RET, `OP_RETA, `OP_INTERRUPT_RETURN: begin
              s_d.pc = stk_top;
              s_d.sp = s_q.sp - 4'h1;
              extra  = 1'b1;
              if (opc(s_q.ir) == `OP_RETA) begin
                s_d.acc = s_q.ir[`ADR_HI:`ADR_LO];
              end
              if (opc(s_q.ir) == `OP_INTERRUPT_RETURN) begin
                s_d.gie = 1'b1;
              end
            end
            `OP_TRDC, `OP_TRDL: begin
              s_d.table_pend = 1'b1;
              s_d.st = ST_EXTRA;
            end
            `OP_CLR: begin
              res = `RST_BYTE;
              wr  = 1'b1;
            end
            `OP_CLRB: begin
              res       = m;
              res[bsel] = 1'b0;
              wr        = 1'b1;
            end
            `OP_SWAP: begin
              res = {m[3:0], m[7:4]};
              wr  = 1'b1;
            end
            `OP_NIBBLE_EXCHANGE_TO_ACC: s_d.acc = {m[3:0], m[7:4]};
            `OP_WCLR: begin
              s_d.wdt    = '0;
              s_d.fl.to  = 1'b0;
              s_d.fl.power_down_flag = 1'b0;
              s_d.pre1   = 1'b0;
              s_d.pre2   = 1'b0;
            end
            `OP_WPRE1, `OP_WPRE2: begin
              // A lone pre-clear is only remembered
              if ((opc(s_q.ir) == `OP_WPRE1 && s_q.pre2) || (opc(s_q.ir) == `OP_WPRE2 && s_q.pre1)) begin
                s_d.wdt    = '0;
                s_d.fl.to  = 1'b0;
                s_d.fl.power_down_flag = 1'b0;
                s_d.pre1   = 1'b0;
                s_d.pre2   = 1'b0;
              end else if (opc(s_q.ir) == `OP_WPRE1) begin
                s_d.pre1 = 1'b1;
              end else begin
                s_d.pre2 = 1'b1;
              end
            end
            `OP_HALT: begin
              s_d.wdt    = '0;
              s_d.fl.power_down_flag = 1'b1;
              s_d.fl.to  = 1'b0;
              s_d.st     = ST_HALTED;
            end
            `OP_ADD, `OP_ADC, `OP_ADDI, `OP_ADD_TO_MEMORY, `OP_ADD_WITH_CARRY_TO_MEMORY: begin
              res       = add_sum;
              s_d.fl.ov = add_ov;
              s_d.fl.ac = add_ac;
              s_d.fl.c  = add_co;
              s_d.fl.z  = (add_sum == 8'h00);
              if (opc(s_q.ir) == `OP_ADD_TO_MEMORY || opc(s_q.ir) == `OP_ADD_WITH_CARRY_TO_MEMORY) begin
                wr = 1'b1;
              end else begin
                s_d.acc = add_sum;
              end
            end
            `OP_AND, `OP_ANDI, `OP_BITWISE_AND_TO_MEMORY: begin
              res      = s_q.acc & ((opc(s_q.ir) == `OP_ANDI) ? s_q.ir[`ADR_HI:`ADR_LO] : m);
              s_d.fl.z = (res == 8'h00);
              if (opc(s_q.ir) == `OP_BITWISE_AND_TO_MEMORY) begin
                wr = 1'b1;
              end else begin
                s_d.acc = res;
              end
            end
            default: ;
          endcase
          // Memory write and penalties; a write to the low byte refetches
          if (wr) begin
            s_d.dm.we    = 1'b1;
            s_d.dm.wdata = res;
            if (writes_pcl(s_q.ir)) begin
              s_d.pc = {s_q.pc[12:8], res};
              extra  = 1'b1;
            end
          end
          if (skip) begin
            s_d.pc = s_d.pc + 13'h0001;
            extra  = 1'b1;
          end
          if (extra && s_d.st == ST_RUN) begin
            s_d.st = ST_EXTRA;
          end
        end
      end
      default: s_d.st = ST_RUN;
    endcase
    // Overflow beats any clear in the same cycle, so a timeout is never lost
    if (WDT_TICK && s_q.st != ST_HALTED && (&s_q.wdt)) begin
      s_d.fl.to = 1'b1;
    end
    // Fetch address is registered so the pin never shows the table mux
    s_d.fetch_addr = (s_d.st == ST_EXTRA && s_d.table_pend)
                   ? (((opc(s_d.ir) == `OP_TRDL) ? {`LAST_PAGE, 8'h00} : {s_d.pc[12:8], 8'h00}) | {5'h00, s_d.acc})
                   : s_d.pc;
  end

  // Register the whole state; clock enable freezes everything
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  always_comb begin
    PROG_ADDR               = s_q.fetch_addr;
    DMEM_WE                 = s_q.dm.we;
    DMEM_ADDR               = s_q.dm.addr;
    DMEM_WDATA              = s_q.dm.wdata;
    ACC                     = s_q.acc;
    TABLE_HIGH_LATCH        = s_q.tbh;
    FLAGS                   = s_q.fl;
    GLOBAL_INTERRUPT_ENABLE = s_q.gie;
    HALTED                  = (s_q.st == ST_HALTED);
    WATCHDOG_COUNTER        = s_q.wdt;
  end

  AST_CALL_TWO: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_CALL) |=> (s_q.st == ST_EXTRA))
    else $error("call did not take a second cycle");
  AST_INTERRUPT_RETURN_GIE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_INTERRUPT_RETURN) |=> s_q.gie)
    else $error("interrupt return left interrupts disabled");
  AST_HALT_FLAGS: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_HALT && !(WDT_TICK && (&s_q.wdt)))
      |=> (s_q.fl.power_down_flag && !s_q.fl.to && HALTED))
    else $error("power-down flags wrong");
  AST_WCLR: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_WCLR) |=> (s_q.wdt == '0 && !s_q.fl.power_down_flag))
    else $error("watchdog clear failed");
  AST_PRE_ALONE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_WPRE1 && !s_q.pre2)
      |=> (s_q.pre1 && $stable(s_q.fl.power_down_flag)))
    else $error("lone pre-clear changed flags");
  AST_SZ_SKIP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_SZ && DMEM_RDATA == 8'h00)
      |=> (s_q.st == ST_EXTRA && s_q.pc == $past(s_q.pc) + 13'h0002))
    else $error("skip not taken");
  AST_CLR_MEM: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_CLR) |=> (DMEM_WE && DMEM_WDATA == 8'h00))
    else $error("clear byte did not write zero");
  AST_AND_Z: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (CE && s_q.st == ST_RUN && s_q.phase == 2'h3 && opc(s_q.ir) == `OP_ANDI)
      |=> (s_q.fl.z == (s_q.acc == 8'h00) && $stable(s_q.fl.c)))
    else $error("and flag effect wrong");
endmodule // insn_core

// file: bench/mem_model.sv
`timescale 1ns/100ps
module mem_model (
  input  wire logic        clk,
  input  wire logic [12:0] prog_addr,
  output logic      [15:0] prog_data,
  input  wire logic        we,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [15:0] rom [8192];
  logic [7:0]  ram [256];
  // Both arrays answer at once; the core picks its own sampling phase
  assign prog_data = rom[prog_addr];
  assign rdata     = ram[addr];
  // One byte per write strobe, no wait states
  always @(posedge clk) begin
    if (we) begin
      ram[addr] <= wdata;
    end
  end
endmodule // mem_model

// file: bench/mcu_instruction_execution_tb_top.sv
`timescale 1ns/100ps
module mcu_instruction_execution_tb_top;
  import core_pkg::*;
  typedef struct packed {
    logic [0:3][15:0] w;
    logic [0:1][15:0] s;
    logic [7:0]       m;
    logic [3:0]       n;
    logic [7:0]       a;
    logic [7:0]       mx;
    logic [5:0]       f;
    logic [7:0]       hi;
    logic             g;
  } row_s;
  localparam logic [31:0] HH = 32'h5C00_5C00;
  logic        mclk;
  logic        reset_n;
  logic        ce;
  logic        wake;
  logic        tick;
  logic [15:0] prog_data;
  logic [7:0]  rdata;
  logic [12:0] prog_addr;
  logic        we;
  logic [7:0]  daddr;
  logic [7:0]  wdata;
  logic [7:0]  acc;
  logic [7:0]  hi_latch;
  logic [5:0]  flags;
  logic        gie;
  logic        halted;
  logic [1:0]  wdc;
  int          err_total;
  int          checked;
  int          c;
  int          c0;
  logic [12:0] pa;
  logic        woke;
  // Program, memory byte at 10h, cycles, acc, memory after, flags, latch, gie
  row_s rows [26] = '{
    '{{HH, HH}, HH, 8'h05, 4'h0, 8'h00, 8'h05, 6'h01, 8'h00, 1'h0},
    '{{32'h687F_6801, HH}, HH, 8'h05, 4'h2, 8'h80, 8'h05, 6'h29, 8'h00, 1'h0},
    '{{32'h68FF_6010, HH}, HH, 8'h01, 4'h2, 8'h00, 8'h01, 6'h1D, 8'h00, 1'h0},
    '{{32'h68FF_6801, 32'h6C10_5C00}, HH, 8'h05, 4'h3, 8'h06, 8'h05, 6'h01, 8'h00, 1'h0},
    '{{32'h68FF_6802, 32'h7010_5C00}, HH, 8'h7E, 4'h3, 8'h01, 8'h80, 6'h29, 8'h00, 1'h0},
    '{{32'h680F_6410, HH}, HH, 8'hF1, 4'h2, 8'h0F, 8'h00, 6'h1D, 8'h00, 1'h0},
    '{{32'h680F_7410, HH}, HH, 8'hF0, 4'h2, 8'h00, 8'hF0, 6'h11, 8'h00, 1'h0},
    '{{32'h68F0_7C3C, 32'h7810_5C00}, HH, 8'h0F, 4'h3, 8'h30, 8'h00, 6'h11, 8'h00, 1'h0},
    '{{32'h4010_5C00, HH}, HH, 8'h5A, 4'h1, 8'h00, 8'h00, 6'h01, 8'h00, 1'h0},
    '{{32'h4710_5C00, HH}, HH, 8'hFF, 4'h1, 8'h00, 8'hBF, 6'h01, 8'h00, 1'h0},
    '{{32'h4810_5C00, HH}, HH, 8'hA5, 4'h1, 8'h00, 8'h5A, 6'h01, 8'h00, 1'h0},
    '{{32'h4C10_5C00, HH}, HH, 8'hA5, 4'h1, 8'h5A, 8'hA5, 6'h01, 8'h00, 1'h0},
    '{{32'h0410_6801, HH}, HH, 8'h00, 4'h2, 8'h00, 8'h00, 6'h01, 8'h00, 1'h0},
    '{{32'h0410_6801, HH}, HH, 8'h03, 4'h2, 8'h01, 8'h03, 6'h01, 8'h00, 1'h0},
    '{{32'h6844_0810, 32'h6801_5C00}, HH, 8'h00, 4'h3, 8'h00, 8'h00, 6'h01, 8'h00, 1'h0},
    '{{32'h0D10_6801, HH}, HH, 8'hFB, 4'h2, 8'h00, 8'hFB, 6'h01, 8'h00, 1'h0},
    '{{32'h1210_6801, HH}, HH, 8'h10, 4'h2, 8'h00, 8'h10, 6'h01, 8'h00, 1'h0},
    '{{32'h1410_6801, HH}, HH, 8'hFF, 4'h2, 8'h00, 8'h00, 6'h01, 8'h00, 1'h0},
    '{{32'h1810_6801, HH}, HH, 8'h02, 4'h2, 8'h01, 8'h01, 6'h01, 8'h00, 1'h0},
    '{{32'h6833_1C10, 32'h6801_5C00}, HH, 8'hFF, 4'h3, 8'h00, 8'hFF, 6'h01, 8'h00, 1'h0},
    '{{32'h6833_2010, 32'h6801_5C00}, HH, 8'h01, 4'h3, 8'h00, 8'h01, 6'h01, 8'h00, 1'h0},
    '{{32'h2403_6801, HH}, 32'h6810_2C00, 8'h05, 4'h6, 8'h11, 8'h05, 6'h01, 8'h00, 1'h0},
    '{{32'h2403_5C00, HH}, 32'h3042_5C00, 8'h05, 4'h4, 8'h42, 8'h05, 6'h01, 8'h00, 1'h0},
    '{{32'h2403_5C00, HH}, 32'h3400_5C00, 8'h05, 4'h4, 8'h00, 8'h05, 6'h01, 8'h00, 1'h1},
    '{{32'h6805_3810, HH}, HH, 8'h00, 4'h3, 8'h05, 8'hA5, 6'h01, 8'hC3, 1'h0},
    '{{32'h6805_3C10, HH}, HH, 8'h00, 4'h3, 8'h05, 8'hC3, 6'h01, 8'h5A, 1'h0}
  };

  // Watchdog width cut to two bits so that an overflow takes four ticks
  insn_core #(.WDT_W(2)) insn_core_i (
    .MCLK(mclk), .RESET_N(reset_n), .CE(ce), .PROG_DATA(prog_data), .DMEM_RDATA(rdata),
    .WAKE(wake), .WDT_TICK(tick), .PROG_ADDR(prog_addr), .DMEM_WE(we), .DMEM_ADDR(daddr),
    .DMEM_WDATA(wdata), .ACC(acc), .TABLE_HIGH_LATCH(hi_latch), .FLAGS(flags),
    .GLOBAL_INTERRUPT_ENABLE(gie), .HALTED(halted), .WATCHDOG_COUNTER(wdc)
  );
  mem_model mem_model_i (
    .clk(mclk), .prog_addr(prog_addr), .prog_data(prog_data), .we(we), .addr(daddr),
    .wdata(wdata), .rdata(rdata)
  );

  // 10 MHz clock
  always #50 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Reset, then load the program while the core is held
  task automatic prep(input logic [0:3][15:0] w, input logic [0:1][15:0] s, input logic [7:0] m);
    @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 4; i++) mem_model_i.rom[i] = w[i];
    mem_model_i.rom[13'h0403] = s[0];
    mem_model_i.rom[13'h0404] = s[1];
    mem_model_i.ram[8'h10] = m;
    @(posedge mclk);
    reset_n <= 1'h1;
  endtask

  // Clocks from release until the core halts; the bound catches a runaway
  task automatic run(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (halted !== 1'h1 && n < 300);
  endtask

  // Five tick pulses overflow the two-bit watchdog once, leaving a count of one
  task automatic wd(input logic [15:0] a, input logic [15:0] b, input logic t);
    prep({16'h0000, 16'h0000, 16'h0000, a}, HH, 8'h00);
    mem_model_i.rom[4] = b;
    mem_model_i.rom[5] = 16'h2802;
    mem_model_i.rom[13'h0802] = 16'h2802;
    repeat (5) begin
      @(posedge mclk);
      tick <= 1'h1;
      @(posedge mclk);
      tick <= 1'h0;
    end
    repeat (40) @(negedge mclk);
    chk(flags, {4'h0, t, 1'h0}, "watchdog flags");
    chk(wdc, t ? 2'h1 : 2'h0, "watchdog count");
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog sized well above the fewer than one thousand clocks the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end

  initial begin
    mclk = 1'h0;
    reset_n = 1'h0;
    ce = 1'h1;
    wake = 1'h0;
    tick = 1'h0;
    err_total = 0;
    checked = 0;
    c0 = 0;
    for (int i = 0; i < 8192; i++) mem_model_i.rom[i] = 16'h5C00;
    for (int i = 0; i < 256; i++) mem_model_i.ram[i] = 8'h00;
    mem_model_i.rom[13'h0005] = 16'hC3A5;
    mem_model_i.rom[13'h1F05] = 16'h5AC3;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk(acc, 8'h00, "reset acc");
    chk(flags, 6'h00, "reset flags");
    // Cycle counts are taken against the lone power-down row
    foreach (rows[k]) begin
      prep(rows[k].w, rows[k].s, rows[k].m);
      run(c);
      if (k == 0) c0 = c;
      chk(16'(c - c0), 16'(4 * rows[k].n), "cycles");
      chk(acc, rows[k].a, "acc");
      chk(mem_model_i.ram[8'h10], rows[k].mx, "memory");
      chk(flags, rows[k].f, "flags");
      chk(hi_latch, rows[k].hi, "latch");
      chk(gie, rows[k].g, "gie");
    end
    // Halted core must hold its fetch address until woken
    pa = prog_addr;
    repeat (8) @(negedge mclk);
    chk(prog_addr, pa, "halt address");
    @(posedge mclk);
    wake <= 1'h1;
    woke = 1'h0;
    repeat (8) begin
      @(negedge mclk);
      if (halted === 1'h0) woke = 1'h1;
    end
    chk(woke, 1'h1, "wake");
    @(posedge mclk);
    wake <= 1'h0;
    wd(16'h5400, 16'h0000, 1'h1);
    wd(16'h5800, 16'h0000, 1'h1);
    wd(16'h5400, 16'h5800, 1'h0);
    wd(16'h5000, 16'h0000, 1'h0);
    // Clock enable low must freeze the watchdog; three ticks would show if it leaked
    @(posedge mclk);
    ce <= 1'h0;
    tick <= 1'h1;
    repeat (3) @(posedge mclk);
    tick <= 1'h0;
    ce <= 1'h1;
    @(negedge mclk);
    chk(wdc, 2'h0, "frozen watchdog");
    results();
  end
endmodule // mcu_instruction_execution_tb_top
